// file: mafp_cfg.svh
// Register map, field positions and fixed values of the MAC address/pause configuration block.
// Assumes byte addresses on a 32-bit AXI4-Lite bus, one aligned word per register.
`ifndef MAFP_CFG_SVH
`define MAFP_CFG_SVH

// Register byte offsets
`define MAFP_OFF_SA_LOWER 8'h00
`define MAFP_OFF_SA_UPPER 8'h04
`define MAFP_OFF_PAUSE 8'h08
`define MAFP_OFF_UC_HI 8'h0c
`define MAFP_OFF_UC_LO 8'h10
`define MAFP_OFF_MC_HI 8'h14
`define MAFP_OFF_MC_LO 8'h18
`define MAFP_OFF_WM 8'h1c
`define MAFP_OFF_BOUND 8'h20
`define MAFP_OFF_STATUS 8'h24

// Fixed pause-frame fields
`define MAFP_PAUSE_TYPE 16'h8808
`define MAFP_PAUSE_OPCODE 16'h0001

// FIFO bound register: bound field and the reserved bit that reads as one
`define MAFP_BOUND_LSB 2
`define MAFP_BOUND_ONE_BIT 21
`define MAFP_FIFO_BOUND 8'hbf

// Transmit start thresholds in bytes
`define MAFP_WM_LOW 11'h040
`define MAFP_WM_MID 11'h080
`define MAFP_WM_HIGH 11'h0c0

// Group bit of the destination address (least significant bit of byte 0)
`define MAFP_GROUP_BIT 40

// AXI responses
`define MAFP_RESP_OKAY 2'h0
`define MAFP_RESP_SLVERR 2'h2

`endif

// file: mafp_pkg.sv
// Types shared by the MAC address/pause configuration block.
// Assumes mafp_cfg.svh supplies the numeric constants.
package mafp_pkg;
    typedef logic [31:0] mafp_word_t;
    typedef enum logic [1:0] {
        MAFP_WR_COLLECT = 2'b01,
        MAFP_WR_RESP = 2'b10
    } mafp_wr_state_e;
endpackage

// file: mafp_hash_lookup.sv
// 64-entry hash table bit select for the receive address filter.
// Assumes tables and index come from logic on the same clock.
`timescale 1ns/1ns
module mafp_hash_lookup
    import mafp_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic lookup_valid,
    input wire logic lookup_group,
    input wire logic [5:0] hash_index,
    input wire mafp_word_t uc_hi,
    input wire mafp_word_t uc_lo,
    input wire mafp_word_t mc_hi,
    input wire mafp_word_t mc_lo,
    output logic hash_hit
);
    logic hash_hit_reg;
    logic hash_hit_next;
    logic [63:0] table_sel;

    // Upper word holds indices 63..32, lower word 31..0, in bit order
    always_comb begin
        table_sel = lookup_group ? {mc_hi, mc_lo} : {uc_hi, uc_lo};
        hash_hit_next = hash_hit_reg;
        if (lookup_valid) begin
            hash_hit_next = table_sel[hash_index];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hash_hit_reg <= 1'b0;
        end else begin
            hash_hit_reg <= hash_hit_next;
        end
    end

    assign hash_hit = hash_hit_reg;
endmodule

// file: mafp_cfg_top.sv
// How it works
// - Match destination against 48-bit station address.
// - Pause frame source uses station bytes 4,5.
// - Byte 4 in 31:24, byte 5 in 23:16.
// - Low half reads 0x8808, used as type.
// - Pause opcode fixed at 0x0001.
// - Programmed pause time copied into pause frames.
// - Unicast frames filtered through 64-bit hash.
// - Unicast upper word covers indices 63..32.
// - Unicast lower word covers indices 31..0.
// - Multicast frames filtered through separate hash.
// - Multicast upper word covers indices 63..32.
// - Multicast lower word covers indices 31..0.
// - Transmit waits for 64/128/192 byte watermark.
// - Readable FIFO RAM upper bound register.
// - Lower register supplies station bytes 0..3.
// - Bound field holds highest FIFO RAM address.
// - Watermark reached raises transmit enable.
//
// Top of the configuration block: AXI4-Lite slave, address filter and transmit start.
// Assumes rx and tx engine signals are on aclk; the hash index comes from the rx CRC logic.
//
// Our own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
`include "mafp_cfg.svh"
module mafp_cfg_top
    import mafp_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rx_check_valid,
    input wire logic [47:0] rx_da,
    input wire logic [5:0] rx_hash_index,
    output logic rx_result_valid,
    output logic rx_exact_match,
    output logic rx_hash_hit,
    output logic [47:0] pause_src_addr,
    output logic [15:0] pause_type,
    output logic [15:0] pause_opcode,
    output logic [15:0] pause_time_field,
    input wire logic tx_frame_pending,
    input wire logic [10:0] tx_fifo_level,
    input wire logic tx_frame_done,
    output logic phy_tx_enable
);
    // Configuration registers
    mafp_word_t sa_lower_reg, sa_lower_next;
    logic [15:0] sa_upper_reg, sa_upper_next;
    logic [15:0] pause_time_reg, pause_time_next;
    mafp_word_t uc_hi_reg, uc_hi_next, uc_lo_reg, uc_lo_next;
    mafp_word_t mc_hi_reg, mc_hi_next, mc_lo_reg, mc_lo_next;
    logic [1:0] wm_reg, wm_next;
    // AXI write side
    mafp_wr_state_e wr_state_reg, wr_state_next;
    logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
    logic [7:0] aw_addr_reg, aw_addr_next;
    mafp_word_t w_data_reg, w_data_next;
    logic [3:0] w_strb_reg, w_strb_next;
    logic awready_reg, awready_next, wready_reg, wready_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic do_write;
    // AXI read side
    logic arready_reg, arready_next, rvalid_reg, rvalid_next;
    mafp_word_t rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;
    logic [7:0] rd_addr_reg, rd_addr_next;
    // Receive and transmit datapath
    logic rx_valid_reg, rx_valid_next, exact_reg, exact_next;
    logic tx_en_reg, tx_en_next;
    logic hash_hit_w;

    // Bytes needed in the transmit FIFO before a frame may start
    function automatic logic [10:0] wm_threshold(input logic [1:0] wm);
        case (wm)
            2'b10: wm_threshold = `MAFP_WM_MID;
            2'b11: wm_threshold = `MAFP_WM_HIGH;
            default: wm_threshold = `MAFP_WM_LOW;
        endcase
    endfunction

    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a <= `MAFP_OFF_STATUS) && (a[1:0] == 2'b00);
    endfunction

    function automatic mafp_word_t merge_strb(input mafp_word_t old_v, input mafp_word_t new_v,
                                              input logic [3:0] strb);
        for (int i = 0; i < 4; i++) begin
            merge_strb[i*8 +: 8] = strb[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
        end
    endfunction

    // Read view of every register; fixed fields and reserved bits come from here
    function automatic mafp_word_t read_word(input logic [7:0] a);
        read_word = 32'h0000_0000;
        case (a)
            `MAFP_OFF_SA_LOWER: read_word = sa_lower_reg;
            `MAFP_OFF_SA_UPPER: read_word = {sa_upper_reg, `MAFP_PAUSE_TYPE};
            `MAFP_OFF_PAUSE: read_word = {`MAFP_PAUSE_OPCODE, pause_time_reg};
            `MAFP_OFF_UC_HI: read_word = uc_hi_reg;
            `MAFP_OFF_UC_LO: read_word = uc_lo_reg;
            `MAFP_OFF_MC_HI: read_word = mc_hi_reg;
            `MAFP_OFF_MC_LO: read_word = mc_lo_reg;
            `MAFP_OFF_WM: read_word = {30'h0000_0000, wm_reg};
            `MAFP_OFF_BOUND: begin
                read_word[`MAFP_BOUND_LSB +: 8] = `MAFP_FIFO_BOUND;
                read_word[`MAFP_BOUND_ONE_BIT] = 1'b1;
            end
            `MAFP_OFF_STATUS: read_word = {29'h0000_0000, rx_hash_hit, exact_reg, tx_en_reg};
            default: read_word = 32'h0000_0000;
        endcase
    endfunction

    // Write channel: address and data may arrive in either order, then one response
    always_comb begin
        wr_state_next = wr_state_reg;
        aw_have_next = aw_have_reg;
        w_have_next = w_have_reg;
        aw_addr_next = aw_addr_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        do_write = 1'b0;
        case (wr_state_reg)
            MAFP_WR_COLLECT: begin
                if (s_axi_awvalid && awready_reg) begin
                    aw_have_next = 1'b1;
                    aw_addr_next = s_axi_awaddr;
                end
                if (s_axi_wvalid && wready_reg) begin
                    w_have_next = 1'b1;
                    w_data_next = s_axi_wdata;
                    w_strb_next = s_axi_wstrb;
                end
                if (aw_have_reg && w_have_reg) begin
                    do_write = 1'b1;
                    aw_have_next = 1'b0;
                    w_have_next = 1'b0;
                    bvalid_next = 1'b1;
                    bresp_next = addr_known(aw_addr_reg) ? `MAFP_RESP_OKAY : `MAFP_RESP_SLVERR;
                    wr_state_next = MAFP_WR_RESP;
                end
            end
            MAFP_WR_RESP: begin
                if (s_axi_bready) begin
                    bvalid_next = 1'b0;
                    wr_state_next = MAFP_WR_COLLECT;
                end
            end
            default: wr_state_next = MAFP_WR_COLLECT;
        endcase
        awready_next = (wr_state_next == MAFP_WR_COLLECT) && !aw_have_next;
        wready_next = (wr_state_next == MAFP_WR_COLLECT) && !w_have_next;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_reg <= MAFP_WR_COLLECT;
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `MAFP_RESP_OKAY;
        end else begin
            wr_state_reg <= wr_state_next;
            aw_have_reg <= aw_have_next;
            w_have_reg <= w_have_next;
            aw_addr_reg <= aw_addr_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
        end
    end

    // Configuration storage; fixed halves are never stored, so writes to them are dropped
    always_comb begin
        sa_lower_next = sa_lower_reg;
        sa_upper_next = sa_upper_reg;
        pause_time_next = pause_time_reg;
        uc_hi_next = uc_hi_reg;
        uc_lo_next = uc_lo_reg;
        mc_hi_next = mc_hi_reg;
        mc_lo_next = mc_lo_reg;
        wm_next = wm_reg;
        if (do_write) begin
            case (aw_addr_reg)
                `MAFP_OFF_SA_LOWER: sa_lower_next = merge_strb(sa_lower_reg, w_data_reg, w_strb_reg);
                `MAFP_OFF_SA_UPPER: sa_upper_next = 16'(merge_strb({sa_upper_reg, 16'h0000},
                    w_data_reg, w_strb_reg) >> 16);
                `MAFP_OFF_PAUSE: pause_time_next = 16'(merge_strb({16'h0000, pause_time_reg},
                    w_data_reg, w_strb_reg));
                `MAFP_OFF_UC_HI: uc_hi_next = merge_strb(uc_hi_reg, w_data_reg, w_strb_reg);
                `MAFP_OFF_UC_LO: uc_lo_next = merge_strb(uc_lo_reg, w_data_reg, w_strb_reg);
                `MAFP_OFF_MC_HI: mc_hi_next = merge_strb(mc_hi_reg, w_data_reg, w_strb_reg);
                `MAFP_OFF_MC_LO: mc_lo_next = merge_strb(mc_lo_reg, w_data_reg, w_strb_reg);
                `MAFP_OFF_WM: if (w_strb_reg[0]) wm_next = w_data_reg[1:0];
                default: wm_next = wm_reg;
            endcase
        end
    end

    // Cleared at reset only so simulation starts defined; software must still program these
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sa_lower_reg <= 32'h0000_0000;
            sa_upper_reg <= 16'h0000;
            pause_time_reg <= 16'h0000;
            uc_hi_reg <= 32'h0000_0000;
            uc_lo_reg <= 32'h0000_0000;
            mc_hi_reg <= 32'h0000_0000;
            mc_lo_reg <= 32'h0000_0000;
            wm_reg <= 2'b00;
        end else begin
            sa_lower_reg <= sa_lower_next;
            sa_upper_reg <= sa_upper_next;
            pause_time_reg <= pause_time_next;
            uc_hi_reg <= uc_hi_next;
            uc_lo_reg <= uc_lo_next;
            mc_hi_reg <= mc_hi_next;
            mc_lo_reg <= mc_lo_next;
            wm_reg <= wm_next;
        end
    end

    // Read channel: one read in flight, data sampled at the address handshake
    always_comb begin
        arready_next = arready_reg;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        rd_addr_next = rd_addr_reg;
        if (s_axi_arvalid && arready_reg) begin
            arready_next = 1'b0;
            rvalid_next = 1'b1;
            rdata_next = read_word(s_axi_araddr);
            rresp_next = addr_known(s_axi_araddr) ? `MAFP_RESP_OKAY : `MAFP_RESP_SLVERR;
            rd_addr_next = s_axi_araddr;
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
            arready_next = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= `MAFP_RESP_OKAY;
            rd_addr_reg <= 8'h00;
        end else begin
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
            rd_addr_reg <= rd_addr_next;
        end
    end

    // Hash bit select lives in its own module so rx can swap in a wider table later
    mafp_hash_lookup u_hash (
        .aclk(aclk),
        .aresetn(aresetn),
        .lookup_valid(rx_check_valid),
        .lookup_group(rx_da[`MAFP_GROUP_BIT]),
        .hash_index(rx_hash_index),
        .uc_hi(uc_hi_reg),
        .uc_lo(uc_lo_reg),
        .mc_hi(mc_hi_reg),
        .mc_lo(mc_lo_reg),
        .hash_hit(hash_hit_w)
    );

    // Exact match and transmit start; done ends the enable even if the level stays high
    always_comb begin
        rx_valid_next = rx_check_valid;
        exact_next = exact_reg;
        if (rx_check_valid) begin
            exact_next = !rx_da[`MAFP_GROUP_BIT] && (rx_da == {sa_lower_reg, sa_upper_reg});
        end
        tx_en_next = tx_en_reg;
        if (tx_frame_done) begin
            tx_en_next = 1'b0;
        end else if (tx_frame_pending && (tx_fifo_level >= wm_threshold(wm_reg))) begin
            tx_en_next = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_valid_reg <= 1'b0;
            exact_reg <= 1'b0;
            tx_en_reg <= 1'b0;
        end else begin
            rx_valid_reg <= rx_valid_next;
            exact_reg <= exact_next;
            tx_en_reg <= tx_en_next;
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign rx_result_valid = rx_valid_reg;
    assign rx_exact_match = exact_reg;
    assign rx_hash_hit = hash_hit_w;
    assign pause_src_addr = {sa_lower_reg, sa_upper_reg};
    assign pause_type = `MAFP_PAUSE_TYPE;
    assign pause_opcode = `MAFP_PAUSE_OPCODE;
    assign pause_time_field = pause_time_reg;
    assign phy_tx_enable = tx_en_reg;

    // Checks
    property p_exact;
        @(posedge aclk) disable iff (!aresetn)
        rx_check_valid |=> rx_exact_match == (!$past(rx_da[40]) && $past(rx_da) == pause_src_addr);
    endproperty
    a_exact: assert property (p_exact) else $error("exact match wrong");
    property p_src_write;
        @(posedge aclk) disable iff (!aresetn)
        do_write && aw_addr_reg == `MAFP_OFF_SA_UPPER && w_strb_reg == 4'hf
        |=> pause_src_addr[15:0] == $past(w_data_reg[31:16]);
    endproperty
    a_src_write: assert property (p_src_write) else $error("station bytes 4,5 not stored");
    property p_type_read;
        @(posedge aclk) disable iff (!aresetn)
        rvalid_reg && rd_addr_reg == `MAFP_OFF_SA_UPPER |-> s_axi_rdata[15:0] == 16'h8808;
    endproperty
    a_type_read: assert property (p_type_read) else $error("type field wrong");
    property p_opcode_read;
        @(posedge aclk) disable iff (!aresetn)
        rvalid_reg && rd_addr_reg == `MAFP_OFF_PAUSE |-> s_axi_rdata[31:16] == 16'h0001;
    endproperty
    a_opcode_read: assert property (p_opcode_read) else $error("opcode field wrong");
    property p_wm_read;
        @(posedge aclk) disable iff (!aresetn)
        rvalid_reg && rd_addr_reg == `MAFP_OFF_WM |-> s_axi_rdata[31:2] == 30'h0;
    endproperty
    a_wm_read: assert property (p_wm_read) else $error("watermark reserved bits set");
    property p_bound_read;
        @(posedge aclk) disable iff (!aresetn)
        rvalid_reg && rd_addr_reg == `MAFP_OFF_BOUND |-> s_axi_rdata == 32'h0020_02fc;
    endproperty
    a_bound_read: assert property (p_bound_read) else $error("bound register wrong");
    property p_tx_start;
        @(posedge aclk) disable iff (!aresetn)
        !phy_tx_enable && !tx_frame_done |=> phy_tx_enable == ($past(tx_frame_pending)
            && $past(tx_fifo_level) >= (($past(wm_reg) == 2'b11) ? 11'd192
            : ($past(wm_reg) == 2'b10) ? 11'd128 : 11'd64));
    endproperty
    a_tx_start: assert property (p_tx_start) else $error("transmit start threshold wrong");
    property p_hash;
        @(posedge aclk) disable iff (!aresetn)
        rx_check_valid |=> 64'(rx_hash_hit) == (((
            $past(rx_da[40]) ? $past({mc_hi_reg, mc_lo_reg}) : $past({uc_hi_reg, uc_lo_reg}))
            >> $past(rx_hash_index)) & 64'h1);
    endproperty
    a_hash: assert property (p_hash) else $error("hash lookup wrong");
    c_exact: cover property (@(posedge aclk) disable iff (!aresetn) rx_result_valid && rx_exact_match);
    c_mc_hit: cover property (@(posedge aclk) disable iff (!aresetn) rx_check_valid && rx_da[40] ##1 rx_hash_hit);
    c_tx_rise: cover property (@(posedge aclk) disable iff (!aresetn) $rose(phy_tx_enable));
    c_wr_resp: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_bvalid && s_axi_bready);
endmodule

// file: mafp_phy_model.sv
// Stand-in for the transmit engine and PHY beyond the transmit start logic.
// Assumes phy_tx_enable is a registered level on aclk; HOLD sets a short or long frame.
`timescale 1ns/1ns
module mafp_phy_model #(parameter int HOLD = 4) (
    input wire logic aclk,
    input wire logic phy_tx_enable,
    output logic tx_frame_done
);
    int cnt = 0;
    initial tx_frame_done = 1'b0;
    // Count frame cycles, then end the frame with a one-cycle done pulse
    always @(posedge aclk) begin
        tx_frame_done <= 1'b0;
        if (phy_tx_enable && !tx_frame_done) begin
            cnt <= cnt + 1;
            if (cnt == HOLD) begin
                tx_frame_done <= 1'b1;
                cnt <= 0;
            end
        end
    end
endmodule

// file: mafp_cfg_top_tb.sv
// Self-checking bench for the address filter and pause configuration block.
// Assumes the register map of mafp_cfg.svh and the PHY stand-in mafp_phy_model.
`timescale 1ns/1ns
`include "mafp_cfg.svh"
module mafp_cfg_top_tb import mafp_pkg::*;;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic rx_check_valid = 1'b0, rx_result_valid, rx_exact_match, rx_hash_hit;
    logic [47:0] rx_da = 48'h0, pause_src_addr;
    logic [5:0] rx_hash_index = 6'h00;
    logic [15:0] pause_type, pause_opcode, pause_time_field;
    logic tx_frame_pending = 1'b0, tx_frame_done, phy_tx_enable;
    logic [10:0] tx_fifo_level = 11'h000;
    int n_errors = 0, checks_done = 0;

    // Free-running 10 MHz clock
    always #50 aclk = ~aclk;

    mafp_cfg_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .rx_check_valid(rx_check_valid), .rx_da(rx_da), .rx_hash_index(rx_hash_index),
        .rx_result_valid(rx_result_valid), .rx_exact_match(rx_exact_match),
        .rx_hash_hit(rx_hash_hit), .pause_src_addr(pause_src_addr), .pause_type(pause_type),
        .pause_opcode(pause_opcode), .pause_time_field(pause_time_field),
        .tx_frame_pending(tx_frame_pending), .tx_fifo_level(tx_fifo_level),
        .tx_frame_done(tx_frame_done), .phy_tx_enable(phy_tx_enable));

    mafp_phy_model #(.HOLD(5)) phy (.aclk(aclk), .phy_tx_enable(phy_tx_enable),
        .tx_frame_done(tx_frame_done));

    task final_report;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task chk(input logic [47:0] got, input logic [47:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask

    // Ready is sampled mid-cycle, so the handshake edge is known before it arrives
    task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int i;
        logic ha, hw, hb;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(negedge aclk);
            ha = s_axi_awvalid && s_axi_awready;
            hw = s_axi_wvalid && s_axi_wready;
            hb = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (ha) s_axi_awvalid <= 1'b0;
            if (hw) s_axi_wvalid <= 1'b0;
            if (hb) s_axi_bready <= 1'b0;
            if (hb) break;
        end
        if (i == 40) begin
            n_errors++;
            final_report();
        end
    endtask

    task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int i;
        logic ha, hr;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(negedge aclk);
            ha = s_axi_arvalid && s_axi_arready;
            hr = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ha) s_axi_arvalid <= 1'b0;
            if (hr) s_axi_rready <= 1'b0;
            if (hr) break;
        end
        if (i == 40) begin
            n_errors++;
            final_report();
        end
    endtask

    // One filter check; the answer is judged half a cycle after the edge that takes it
    task rx_chk(input logic [47:0] da, input logic [5:0] idx, input logic ex, input logic hit);
        @(posedge aclk);
        rx_check_valid <= 1'b1;
        rx_da <= da;
        rx_hash_index <= idx;
        @(posedge aclk);
        rx_check_valid <= 1'b0;
        @(negedge aclk);
        chk(rx_result_valid, 1'b1);
        chk(rx_exact_match, ex);
        chk(rx_hash_hit, hit);
    endtask

    task t_regs;
        axi_rd(`MAFP_OFF_BOUND, rd, rs);
        chk(rd, 32'h002002fc);
        axi_wr(`MAFP_OFF_WM, 32'hffffffff, rs);
        axi_rd(`MAFP_OFF_WM, rd, rs);
        chk(rd, 32'h00000003);
        axi_wr(8'h28, 32'h12345678, rs);
        chk(rs, `MAFP_RESP_SLVERR);
        axi_rd(8'h28, rd, rs);
        chk(rs, `MAFP_RESP_SLVERR);
        $display("test regs done");
    endtask

    task t_station;
        axi_wr(`MAFP_OFF_SA_LOWER, 32'h10223344, rs);
        axi_wr(`MAFP_OFF_SA_UPPER, 32'h5566ffff, rs);
        axi_rd(`MAFP_OFF_SA_UPPER, rd, rs);
        chk(rd, 32'h55668808);
        chk(pause_src_addr, 48'h102233445566);
        chk(pause_type, 16'h8808);
        axi_wr(`MAFP_OFF_PAUSE, 32'hffff1234, rs);
        axi_rd(`MAFP_OFF_PAUSE, rd, rs);
        chk(rd, 32'h00011234);
        chk(pause_opcode, 16'h0001);
        chk(pause_time_field, 16'h1234);
        rx_chk(48'h102233445566, 6'h00, 1'b1, 1'b0);
        axi_rd(`MAFP_OFF_STATUS, rd, rs);
        chk(rd, 32'h00000002);
        rx_chk(48'h102233445567, 6'h00, 1'b0, 1'b0);
        $display("test station done");
    endtask

    // Hi word holds only index 63, lo word only index 0: swaps or bit reversal show up
    task t_hash;
        int idxs[6] = '{63, 0, 32, 31, 62, 1};
        for (int g = 0; g < 2; g++) begin
            axi_wr(`MAFP_OFF_UC_HI, g ? 32'h0 : 32'h80000000, rs);
            axi_wr(`MAFP_OFF_UC_LO, g ? 32'h0 : 32'h00000001, rs);
            axi_wr(`MAFP_OFF_MC_HI, g ? 32'h80000000 : 32'h0, rs);
            axi_wr(`MAFP_OFF_MC_LO, g ? 32'h00000001 : 32'h0, rs);
            for (int k = 0; k < 6; k++) begin
                rx_chk(48'h020000000000, idxs[k][5:0], 1'b0, g == 0 && k < 2);
                rx_chk(48'h010000000000, idxs[k][5:0], 1'b0, g == 1 && k < 2);
            end
        end
        $display("test hash done");
    endtask

    // Each threshold is tried one byte short and exactly met
    task t_tx;
        int thr;
        int i;
        for (int wm = 0; wm < 4; wm++) begin
            thr = wm == 3 ? 192 : (wm == 2 ? 128 : 64);
            axi_wr(`MAFP_OFF_WM, wm, rs);
            for (int k = 0; k < 2; k++) begin
                @(posedge aclk);
                tx_frame_pending <= 1'b1;
                tx_fifo_level <= 11'(thr - 1 + k);
                @(posedge aclk);
                tx_frame_pending <= 1'b0;
                @(negedge aclk);
                chk(phy_tx_enable, k);
                for (i = 0; i < 20 && phy_tx_enable; i++) @(negedge aclk);
                chk(phy_tx_enable, 1'b0);
                if (i == 20) final_report;
            end
        end
        $display("test tx done");
    endtask

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs;
        t_station;
        t_hash;
        t_tx;
        final_report;
    end
endmodule
